// ---- design/tsm_timer.sv ----
// Our own choices: the Wishbone slave port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module tsm_timer (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic [3:0]  internal_source_i,
  input  wire logic        ch1_raw_i,
  input  wire logic        filtered_input_one_i,
  input  wire logic        filtered_input_two_i,
  input  wire logic        ch1_event_i,
  input  wire logic        ch2_event_i,
  output logic             ovf_event_o,
  output logic             irq_o
);

  logic [15:0] ctrl_reg,  ctrl_next;
  logic [15:0] stctl_reg, stctl_next;
  logic [15:0] ien_reg,   ien_next;
  logic [15:0] sts_reg,   sts_next;
  logic [15:0] cnt_reg,   cnt_next;
  logic [15:0] div_reg,   div_next;
  logic [15:0] psc_reg,   psc_next;
  // Software sees the period buffer; the counter compares the active period
  logic [15:0] perb_reg,  perb_next;
  logic [15:0] pera_reg,  pera_next;
  // Previous trigger level; resets to the idle low level so no false edge
  logic        trgp_reg,  trgp_next;
  logic        ch1p_reg,  ch1p_next;
  logic        ack_reg,   ack_next;
  logic [31:0] dat_reg,   dat_next;
  logic        ovfe_reg,  ovfe_next;
  logic        irq_reg,   irq_next;

  // Only the two low byte lanes carry register bits
  function automatic logic [15:0] lane_mask(input logic [3:0] sel);
    lane_mask = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] wd,
                                        input logic [15:0] m);
    merge = (old & ~m) | (wd & m);
  endfunction

  logic        req;
  logic        wr;
  logic [15:0] wd;
  logic [15:0] wm;
  logic [2:0]  smode;
  logic [2:0]  tsel;
  logic        trg;
  logic        rise;
  logic        fall;
  logic        ch1_edge;
  logic        sw_ovf;
  logic        slv_rst;
  logic        cnt_en;
  logic        psc_tick;
  logic        ovf;
  logic        update;

  always_comb begin
    req      = wb_cyc_i & wb_stb_i & ~ack_reg;
    wr       = req & wb_we_i;
    wd       = wb_dat_i[15:0];
    wm       = lane_mask(wb_sel_i);
    smode    = stctl_reg[tsm_pkg::SMS_LSB +: 3];
    tsel     = stctl_reg[tsm_pkg::STS_LSB +: 3];
    // Any change of the raw channel one pin gives a one-cycle pulse, so
    // reset and external clock modes see one rise per pin edge
    ch1_edge = ch1_raw_i ^ ch1p_reg;
    // Trigger input selection
    if (tsel == tsm_pkg::TS_CH1E) begin
      trg = ch1_edge;
    end else if (tsel == tsm_pkg::TS_F1) begin
      trg = filtered_input_one_i;
    end else if (tsel == tsm_pkg::TS_F2) begin
      trg = filtered_input_two_i;
    end else if (tsel[2] == 1'b0) begin
      trg = internal_source_i[tsel[1:0]];
    end else begin
      // Reserved code 111 holds the trigger low so no mode can fire
      trg = 1'b0;
    end
    // Edges of the selected source against its level one cycle earlier
    rise = trg & ~trgp_reg;
    fall = ~trg & trgp_reg;

    ctrl_next  = ctrl_reg;
    stctl_next = stctl_reg;
    ien_next   = ien_reg;
    sts_next   = sts_reg;
    cnt_next   = cnt_reg;
    div_next   = div_reg;
    perb_next  = perb_reg;
    pera_next  = pera_reg;
    sw_ovf     = 1'b0;

    // Bus writes first; hardware events below take precedence
    // Writes to unmapped addresses are dropped without effect
    if (wr) begin
      if (wb_adr_i == tsm_pkg::ADDR_CTRL) begin
        ctrl_next = merge(ctrl_reg, wd, wm & tsm_pkg::MASK_CTRL);
      end else if (wb_adr_i == tsm_pkg::ADDR_STCTL) begin
        stctl_next = merge(stctl_reg, wd, wm & tsm_pkg::MASK_STCTL);
      end else if (wb_adr_i == tsm_pkg::ADDR_IEN) begin
        ien_next = merge(ien_reg, wd, wm & tsm_pkg::MASK_IEN);
      end else if (wb_adr_i == tsm_pkg::ADDR_STS) begin
        // Writing zero clears a flag, writing one leaves it
        sts_next = sts_reg & ~(~wd & wm & tsm_pkg::MASK_STS);
      end else if (wb_adr_i == tsm_pkg::ADDR_SWEV) begin
        sw_ovf = wd[tsm_pkg::BIT_SWOVF] & wm[tsm_pkg::BIT_SWOVF];
      end else if (wb_adr_i == tsm_pkg::ADDR_CNT) begin
        cnt_next = merge(cnt_reg, wd, wm);
      end else if (wb_adr_i == tsm_pkg::ADDR_DIV) begin
        div_next = merge(div_reg, wd, wm);
      end else if (wb_adr_i == tsm_pkg::ADDR_PER) begin
        perb_next = merge(perb_reg, wd, wm);
        if (!ctrl_reg[tsm_pkg::BIT_PPE]) begin
          pera_next = merge(perb_reg, wd, wm);
        end
      end
    end

    // Slave controller
    slv_rst = 1'b0;
    cnt_en  = ctrl_reg[tsm_pkg::BIT_RUN];
    case (smode)
      tsm_pkg::SM_RST: begin
        slv_rst = rise;
      end
      tsm_pkg::SM_SUSP: begin
        // Trigger low stops counting in the very cycle it falls
        cnt_en = cnt_en & trg;
      end
      tsm_pkg::SM_TRIG: begin
        // Rise sets the run bit; software may clear it again later
        if (rise) begin
          ctrl_next[tsm_pkg::BIT_RUN] = 1'b1;
        end
      end
      tsm_pkg::SM_EXTA: begin
        // One count enable per rise; the divider still applies
        cnt_en = cnt_en & rise;
      end
      default: begin
        // Reserved modes 001 to 011 act as disabled
        cnt_en = cnt_en;
      end
    endcase

    // The prescaler divides by div+1; a period match wraps the counter
    psc_tick = cnt_en & (psc_reg == div_reg);
    ovf      = psc_tick & (cnt_reg == pera_reg);
    update   = ovf | slv_rst | sw_ovf;

    // Reinit outranks a same-cycle counter write and any prescaler tick
    if (slv_rst | sw_ovf) begin
      psc_next = '0;
      cnt_next = '0;
    end else if (psc_tick) begin
      psc_next = '0;
      cnt_next = ovf ? 16'h0000 : cnt_reg + 16'h0001;
    end else if (cnt_en) begin
      psc_next = psc_reg + 16'h0001;
    end else begin
      psc_next = psc_reg;
    end

    if (update) begin
      pera_next = perb_next;
    end
    // Every update event ends a single-cycle run, not only an overflow;
    // a trigger-mode restart in the same cycle therefore loses
    if (update && ctrl_reg[tsm_pkg::BIT_SCS]) begin
      ctrl_next[tsm_pkg::BIT_RUN] = 1'b0;
    end

    // Overflow event source selection
    // The period still reloads on a masked update event
    if (ctrl_reg[tsm_pkg::BIT_OVSRC]) begin
      ovfe_next = ovf;
    end else begin
      ovfe_next = ovf | sw_ovf | slv_rst;
    end

    // Hardware sets win over a clear in the same cycle
    if (ovfe_next) begin
      sts_next[tsm_pkg::BIT_OVF] = 1'b1;
    end
    if (ch1_event_i) begin
      sts_next[tsm_pkg::BIT_CH1] = 1'b1;
    end
    if (ch2_event_i) begin
      sts_next[tsm_pkg::BIT_CH2] = 1'b1;
    end
    if ((smode == tsm_pkg::SM_SUSP) ? (rise | fall) : rise) begin
      sts_next[tsm_pkg::BIT_TRG] = 1'b1;
    end

    // Next values make the request follow its cause by exactly one cycle
    irq_next  = |(sts_next & ien_next);
    trgp_next = trg;
    ch1p_next = ch1_raw_i;
    // Ack only follows a take, so a strobe held high is answered every
    // other cycle; a master releases after each ack
    ack_next  = req;

    // Read data; unmapped words read zero but are still acknowledged
    dat_next = 32'h0000_0000;
    if (req && !wb_we_i) begin
      if (wb_adr_i == tsm_pkg::ADDR_CTRL) begin
        dat_next[15:0] = ctrl_reg;
      end else if (wb_adr_i == tsm_pkg::ADDR_STCTL) begin
        dat_next[15:0] = stctl_reg;
      end else if (wb_adr_i == tsm_pkg::ADDR_IEN) begin
        dat_next[15:0] = ien_reg;
      end else if (wb_adr_i == tsm_pkg::ADDR_STS) begin
        dat_next[15:0] = sts_reg;
      end else if (wb_adr_i == tsm_pkg::ADDR_CNT) begin
        dat_next[15:0] = cnt_reg;
      end else if (wb_adr_i == tsm_pkg::ADDR_DIV) begin
        dat_next[15:0] = div_reg;
      end else if (wb_adr_i == tsm_pkg::ADDR_PER) begin
        dat_next[15:0] = perb_reg;
      end
    end
  end

  // Clock enable low freezes every flop, bus handshake included
  // Reset acts even while the clock enable is low
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg  <= tsm_pkg::RST_VAL;
      stctl_reg <= tsm_pkg::RST_VAL;
      ien_reg   <= tsm_pkg::RST_VAL;
      sts_reg   <= tsm_pkg::RST_VAL;
      cnt_reg   <= tsm_pkg::RST_VAL;
      div_reg   <= tsm_pkg::RST_VAL;
      psc_reg   <= tsm_pkg::RST_VAL;
      perb_reg  <= tsm_pkg::RST_PER;
      pera_reg  <= tsm_pkg::RST_PER;
      trgp_reg  <= 1'b0;
      ch1p_reg  <= 1'b0;
      ack_reg   <= 1'b0;
      dat_reg   <= 32'h0000_0000;
      ovfe_reg  <= 1'b0;
      irq_reg   <= 1'b0;
    end else if (ce_i) begin
      ctrl_reg  <= ctrl_next;
      stctl_reg <= stctl_next;
      ien_reg   <= ien_next;
      sts_reg   <= sts_next;
      cnt_reg   <= cnt_next;
      div_reg   <= div_next;
      psc_reg   <= psc_next;
      perb_reg  <= perb_next;
      pera_reg  <= pera_next;
      trgp_reg  <= trgp_next;
      ch1p_reg  <= ch1p_next;
      ack_reg   <= ack_next;
      dat_reg   <= dat_next;
      ovfe_reg  <= ovfe_next;
      irq_reg   <= irq_next;
    end
  end

  assign wb_dat_o    = dat_reg;
  assign wb_ack_o    = ack_reg;
  assign ovf_event_o = ovfe_reg;
  assign irq_o       = irq_reg;

endmodule
`default_nettype wire

// ---- design/tsm_pkg.sv ----
`default_nettype none
package tsm_pkg;
  localparam int unsigned REG_W = 16;
  // Byte addresses of the word registers
  localparam logic [7:0] ADDR_CTRL  = 8'h00;
  localparam logic [7:0] ADDR_STCTL = 8'h08;
  localparam logic [7:0] ADDR_IEN   = 8'h0c;
  localparam logic [7:0] ADDR_STS   = 8'h10;
  localparam logic [7:0] ADDR_SWEV  = 8'h14;
  localparam logic [7:0] ADDR_CNT   = 8'h24;
  localparam logic [7:0] ADDR_DIV   = 8'h28;
  localparam logic [7:0] ADDR_PER   = 8'h2c;
  // Writable bits of each register; the rest read as zero
  localparam logic [15:0] MASK_CTRL  = 16'h008d;
  localparam logic [15:0] MASK_STCTL = 16'h0077;
  localparam logic [15:0] MASK_IEN   = 16'h0047;
  localparam logic [15:0] MASK_STS   = 16'h0047;
  localparam logic [15:0] RST_VAL    = 16'h0000;
  localparam logic [15:0] RST_PER    = 16'h0000;
  // Control register fields
  localparam int unsigned BIT_RUN  = 0;
  localparam int unsigned BIT_OVSRC = 2;
  localparam int unsigned BIT_SCS  = 3;
  localparam int unsigned BIT_PPE  = 7;
  // Slave control fields
  localparam int unsigned SMS_LSB = 0;
  localparam int unsigned STS_LSB = 4;
  // Enable and status bit positions
  localparam int unsigned BIT_OVF  = 0;
  localparam int unsigned BIT_CH1  = 1;
  localparam int unsigned BIT_CH2  = 2;
  localparam int unsigned BIT_TRG  = 6;
  // Software event register: bit that forces an update event, and an overflow event only with the source bit clear
  localparam int unsigned BIT_SWOVF = 0;
  // Slave mode codes
  localparam logic [2:0] SM_OFF  = 3'h0;
  localparam logic [2:0] SM_RST  = 3'h4;
  localparam logic [2:0] SM_SUSP = 3'h5;
  localparam logic [2:0] SM_TRIG = 3'h6;
  localparam logic [2:0] SM_EXTA = 3'h7;
  // Trigger select codes
  localparam logic [2:0] TS_CH1E = 3'h4;
  localparam logic [2:0] TS_F1   = 3'h5;
  localparam logic [2:0] TS_F2   = 3'h6;
endpackage
`default_nettype wire

// ---- tb/tsm_timer_chk.sv ----
`timescale 1ns/100ps
`default_nettype none
module tsm_timer_chk (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  input wire logic [3:0]  internal_source_i,
  input wire logic        ch1_raw_i,
  input wire logic        filtered_input_one_i,
  input wire logic        filtered_input_two_i,
  input wire logic        ch1_event_i,
  input wire logic        ch2_event_i,
  input wire logic        ovf_event_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic       tk, wr, run_q, swv;
  logic [7:0] ien_q, stm_q;
  assign tk = wb_cyc_i & wb_stb_i & ~wb_ack_o & ce_i;
  assign wr = tk & wb_we_i & wb_sel_i[0];
  // Shadows only see software writes; hardware run changes are not tracked
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ien_q <= 8'h00;
      stm_q <= 8'h00;
      run_q <= 1'b0;
      swv   <= 1'b0;
    end else begin
      if (wr && wb_adr_i == tsm_pkg::ADDR_IEN) begin
        ien_q <= wb_dat_i[7:0] & tsm_pkg::MASK_IEN[7:0];
      end
      if (wr && wb_adr_i == tsm_pkg::ADDR_STCTL) begin
        stm_q <= wb_dat_i[7:0] & tsm_pkg::MASK_STCTL[7:0];
      end
      if (wr && wb_adr_i == tsm_pkg::ADDR_CTRL) begin
        run_q <= wb_dat_i[0];
      end
      swv <= wr && wb_adr_i == tsm_pkg::ADDR_SWEV && wb_dat_i[0];
    end
  end
  sequence s_ack; ##1 wb_ack_o ##1 !wb_ack_o; endsequence
  sequence s_quiet; !run_q && stm_q[2:0] == tsm_pkg::SM_OFF && !swv; endsequence
  property p_ack_walk; tk |-> s_ack; endproperty
  property p_dat_idle; !wb_ack_o |-> wb_dat_o == 32'h0; endproperty
  property p_dat_high; wb_ack_o |-> wb_dat_o[31:16] == 16'h0; endproperty
  property p_rd_ien;
    tk && !wb_we_i && wb_adr_i == tsm_pkg::ADDR_IEN |=> wb_dat_o == {24'h0, ien_q};
  endproperty
  property p_rd_stctl;
    tk && !wb_we_i && wb_adr_i == tsm_pkg::ADDR_STCTL |=> wb_dat_o[7:0] == stm_q;
  endproperty
  property p_unmapped; tk && !wb_we_i && wb_adr_i == 8'h04 |=> wb_dat_o == 32'h0; endproperty
  property p_irq_mask; ien_q == 8'h00 |-> !irq_o; endproperty
  property p_no_ovf; s_quiet [*3] |-> !ovf_event_o; endproperty
  a_ack_walk: assert property (p_ack_walk) else $error("ack not a single pulse after request");
  a_dat_idle: assert property (p_dat_idle) else $error("read data not zero while idle");
  a_dat_high: assert property (p_dat_high) else $error("upper read data not zero");
  a_rd_ien: assert property (p_rd_ien) else $error("enable register readback wrong");
  a_rd_stctl: assert property (p_rd_stctl) else $error("slave control readback wrong");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_irq_mask: assert property (p_irq_mask) else $error("irq with all enables clear");
  a_no_ovf: assert property (p_no_ovf) else $error("overflow while stopped and idle");
endmodule
bind tsm_timer tsm_timer_chk tsm_timer_chk_inst (
  .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .internal_source_i(internal_source_i),
  .ch1_raw_i(ch1_raw_i), .filtered_input_one_i(filtered_input_one_i),
  .filtered_input_two_i(filtered_input_two_i), .ch1_event_i(ch1_event_i),
  .ch2_event_i(ch2_event_i), .ovf_event_o(ovf_event_o), .irq_o(irq_o)
);
`default_nettype wire

// ---- tb/tsm_timer_test.sv ----
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, a) begin comparisons++; if ((a) !== (e)) begin fail_count++; \
  $display("[FAIL] %s exp %h got %h", nm, e, a); end end
module tsm_timer_test;
  logic        clk_i, rst_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, ch1_raw_i, ch1_event_i;
  logic        ch2_event_i, filtered_input_one_i, filtered_input_two_i;
  logic        wb_ack_o, ovf_event_o, irq_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i, internal_source_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [15:0] q, q1, d;
  int          fail_count, comparisons, n, k, p, v, c, ov;
  logic [7:0]  ra [4] = '{tsm_pkg::ADDR_CTRL, tsm_pkg::ADDR_STCTL, tsm_pkg::ADDR_IEN, 8'h04};
  logic [15:0] rm [4] = '{tsm_pkg::MASK_CTRL, tsm_pkg::MASK_STCTL, tsm_pkg::MASK_IEN, 16'h0};
  int          bt [4] = '{0, 1, 2, 6};
  tsm_timer tsm_timer_inst (
    .clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .internal_source_i(internal_source_i),
    .ch1_raw_i(ch1_raw_i), .filtered_input_one_i(filtered_input_one_i),
    .filtered_input_two_i(filtered_input_two_i), .ch1_event_i(ch1_event_i),
    .ch2_event_i(ch2_event_i), .ovf_event_o(ovf_event_o), .irq_o(irq_o)
  );
  task automatic print_verdict;
    if (fail_count == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [15:0] val);
    int t;
    t = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0, val};
    do begin
      @(posedge clk_i);
      t++;
    end while (wb_ack_o !== 1'b1 && t < 20);
    q = wb_dat_o[15:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    if (wb_ack_o !== 1'b1) begin
      fail_count++;
      print_verdict();
    end
  endtask
  task automatic src(input int s, input logic lv);
    if (s < 4) internal_source_i[s] <= lv;
    else if (s == 4) ch1_raw_i <= lv;
    else if (s == 5) filtered_input_one_i <= lv;
    else if (s == 6) filtered_input_two_i <= lv;
  endtask
  task automatic cnt_ovf(input int cyc);
    n = 0;
    repeat (cyc) begin
      @(posedge clk_i);
      n += int'(ovf_event_o === 1'b1);
    end
  endtask
  function automatic int gap(input int per, input int dv);
    return (per + 1) * (dv + 1);
  endfunction
  // A slave reset only yields an overflow event from a valid source with the source bit clear
  function automatic int exp_rst(input int sel, input int os, input int md);
    return int'(sel != 7 && os == 0 && md == 4);
  endfunction
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  initial begin
    {rst_i, ce_i} = 2'b11;
    {wb_cyc_i, wb_stb_i, wb_we_i, ch1_raw_i, ch1_event_i, ch2_event_i} = '0;
    {filtered_input_one_i, filtered_input_two_i, internal_source_i} = '0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hf;
    wb_dat_i = 32'h0;
    void'($urandom(32'hacc0b42a));
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    foreach (ra[i]) begin
      wb(0, ra[i], 0);
      `CHK("reset value", 16'h0000, q)
      d = 16'($urandom);
      if (i == 0) d[0] = 1'b0;
      wb(1, ra[i], d);
      wb(0, ra[i], 0);
      `CHK("readback", d & rm[i], q)
    end
    p = 2 + $urandom % 6;
    v = $urandom % 3;
    wb(1, tsm_pkg::ADDR_STCTL, 0);
    wb(1, tsm_pkg::ADDR_PER, p[15:0]);
    wb(1, tsm_pkg::ADDR_DIV, v[15:0]);
    wb(1, tsm_pkg::ADDR_CNT, 0);
    wb(1, tsm_pkg::ADDR_CTRL, 16'h0009);
    cnt_ovf(3 * gap(p, v) + 8);
    `CHK("single cycle overflows", 1, n)
    wb(0, tsm_pkg::ADDR_CTRL, 0);
    `CHK("run cleared at stop", 16'h0008, q)
    wb(1, tsm_pkg::ADDR_CTRL, 16'h0001);
    repeat (gap(p, v)) @(posedge clk_i);
    cnt_ovf(4 * gap(p, v));
    `CHK("free run overflows", 4, n)
    wb(1, tsm_pkg::ADDR_CTRL, 0);
    cnt_ovf(3 * gap(p, v));
    `CHK("stopped overflows", 0, n)
    for (int i = 0; i < 17; i++) begin
      c = i % 8;
      ov = (i / 8) % 2;
      k = (i == 16) ? 0 : 4;
      wb(1, tsm_pkg::ADDR_CTRL, ov ? 16'h0004 : 16'h0000);
      wb(1, tsm_pkg::ADDR_STCTL, {9'h0, c[2:0], 1'b0, k[2:0]});
      src(c, 1'b1);
      cnt_ovf(4);
      `CHK("slave reset overflow", exp_rst(c, ov, k), n)
      src(c, 1'b0);
      repeat (4) @(posedge clk_i);
    end
    ch1_event_i <= 1'b1;
    ch2_event_i <= 1'b1;
    @(posedge clk_i);
    ch1_event_i <= 1'b0;
    ch2_event_i <= 1'b0;
    wb(0, tsm_pkg::ADDR_STS, 0);
    `CHK("status flags", tsm_pkg::MASK_STS, q)
    foreach (bt[j]) begin
      wb(1, tsm_pkg::ADDR_IEN, 16'h1 << bt[j]);
      @(negedge clk_i);
      `CHK("irq enabled", 1'b1, irq_o)
      wb(1, tsm_pkg::ADDR_STS, ~(16'h1 << bt[j]));
      @(negedge clk_i);
      `CHK("irq cleared", 1'b0, irq_o)
    end
    wb(1, tsm_pkg::ADDR_STCTL, 16'h0005);
    wb(1, tsm_pkg::ADDR_PER, 16'hffff);
    wb(1, tsm_pkg::ADDR_DIV, 0);
    wb(1, tsm_pkg::ADDR_SWEV, 1);
    wb(1, tsm_pkg::ADDR_CNT, 0);
    wb(1, tsm_pkg::ADDR_CTRL, 1);
    k = 3 + $urandom % 8;
    src(0, 1'b1);
    repeat (k) @(posedge clk_i);
    src(0, 1'b0);
    wb(0, tsm_pkg::ADDR_CNT, 0);
    q1 = q;
    `CHK("suspend count", k[15:0], q1)
    repeat (5) @(posedge clk_i);
    wb(0, tsm_pkg::ADDR_CNT, 0);
    `CHK("suspend hold", q1, q)
    src(0, 1'b1);
    wb(1, tsm_pkg::ADDR_STS, 16'hffbf);
    src(0, 1'b0);
    repeat (2) @(posedge clk_i);
    wb(0, tsm_pkg::ADDR_STS, 0);
    `CHK("suspend fall flag", 1'b1, q[tsm_pkg::BIT_TRG])
    wb(1, tsm_pkg::ADDR_STCTL, 16'h0007);
    wb(1, tsm_pkg::ADDR_CNT, 0);
    k = 1 + $urandom % 5;
    repeat (k) begin
      src(0, 1'b1);
      @(posedge clk_i);
      src(0, 1'b0);
      @(posedge clk_i);
    end
    wb(0, tsm_pkg::ADDR_CNT, 0);
    `CHK("external clock count", k[15:0], q)
    wb(1, tsm_pkg::ADDR_CTRL, 16'h0080);
    wb(1, tsm_pkg::ADDR_STCTL, 0);
    wb(1, tsm_pkg::ADDR_PER, 16'h0003);
    wb(1, tsm_pkg::ADDR_CNT, 0);
    wb(1, tsm_pkg::ADDR_CTRL, 16'h0081);
    cnt_ovf(12);
    `CHK("buffered period held", 0, n)
    wb(1, tsm_pkg::ADDR_SWEV, 1);
    cnt_ovf(16);
    `CHK("buffered period loaded", 4, n)
    ce_i <= 1'b0;
    cnt_ovf(8);
    `CHK("frozen overflows", 0, n)
    ce_i <= 1'b1;
    wb(1, tsm_pkg::ADDR_CTRL, 0);
    wb(1, tsm_pkg::ADDR_STCTL, 16'h0006);
    src(0, 1'b1);
    repeat (3) @(posedge clk_i);
    wb(0, tsm_pkg::ADDR_CTRL, 0);
    `CHK("trigger start", 1'b1, q[0])
    print_verdict();
  end
endmodule
`default_nettype wire
